// file: core/timer_status_flag_bank.sv
// wishbone slave holding the timer status flags
//
// Added by the designer: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module timer_status_flag_bank (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [flag_bank_pkg::ADDR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // channel 3 events
    input wire logic [2:0] ch3_capture_i,
    input wire logic [2:0] ch3_capture_by_ch9_i,
    input wire logic [2:0] ch3_compare_match_i,
    input wire logic [2:0] ch3_is_capture_i,
    input wire logic ch3_pwm_mode_i,
    // channels 6 and 7 events
    input wire logic [3:0] ch6_down_count_i,
    input wire logic [3:0] ch6_period_match_i,
    input wire logic [3:0] ch7_period_match_i,
    input wire logic [2:0] ch6_zero_down_i,
    input wire logic ch6_comp_pwm_i,
    // channel 8 underflow pulses, bit 0 counter a
    input wire logic [flag_bank_pkg::OS_W-1:0] oneshot_underflow_i
);
    import flag_bank_pkg::*;

    logic ack_q, ack_d;
    logic [31:0] dat_q, dat_d;
    logic req;
    logic lane_lo;
    logic [2:0] ch3_set;
    logic [3:0] ch6_set;
    logic [3:0] ch7_set;
    logic [3:0] dir_q;
    logic [3:0] dir_d;

    flag_access_if #(.W(CH3_W)) ch3_acc ();
    flag_access_if #(.W(CYC_W)) ch6_acc ();
    flag_access_if #(.W(CYC_W)) ch7_acc ();
    flag_access_if #(.W(OS_W)) ch8_acc ();

    event_decode u_decode (
        .ch3_capture_i(ch3_capture_i),
        .ch3_capture_by_ch9_i(ch3_capture_by_ch9_i),
        .ch3_compare_match_i(ch3_compare_match_i),
        .ch3_is_capture_i(ch3_is_capture_i),
        .ch3_pwm_mode_i(ch3_pwm_mode_i),
        .ch6_period_match_i(ch6_period_match_i),
        .ch7_period_match_i(ch7_period_match_i),
        .ch6_zero_down_i(ch6_zero_down_i),
        .ch6_comp_pwm_i(ch6_comp_pwm_i),
        .ch3_set_o(ch3_set),
        .ch6_set_o(ch6_set),
        .ch7_set_o(ch7_set)
    );

    clear_flag_bank #(.W(CH3_W)) u_ch3 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(ch3_set),
        .acc(ch3_acc.bank)
    );
    clear_flag_bank #(.W(CYC_W)) u_ch6 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(ch6_set),
        .acc(ch6_acc.bank)
    );
    clear_flag_bank #(.W(CYC_W)) u_ch7 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(ch7_set),
        .acc(ch7_acc.bank)
    );
    clear_flag_bank #(.W(OS_W)) u_ch8 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(oneshot_underflow_i),
        .acc(ch8_acc.bank)
    );

    // one access per request; ack_q blocks a second strobe in the ack cycle
    assign req = cyc_i && stb_i && !ack_q;
    // flags live in the low half-word; writes need byte lane 0
    assign lane_lo = sel_i[0];

    assign ch3_acc.rd = req && !we_i && (adr_i == CH3_STATUS_OFS);
    assign ch6_acc.rd = req && !we_i && (adr_i == CH6_STATUS_OFS);
    assign ch7_acc.rd = req && !we_i && (adr_i == CH7_STATUS_OFS);
    assign ch8_acc.rd = req && !we_i && (adr_i == CH8_STATUS_OFS);
    assign ch3_acc.wr = req && we_i && lane_lo && (adr_i == CH3_STATUS_OFS);
    assign ch6_acc.wr = req && we_i && lane_lo && (adr_i == CH6_STATUS_OFS);
    assign ch7_acc.wr = req && we_i && lane_lo && (adr_i == CH7_STATUS_OFS);
    // upper byte of the one-shot flags needs lane 1 as well
    assign ch8_acc.wr = req && we_i && (adr_i == CH8_STATUS_OFS) && (sel_i[1:0] == 2'h3);
    assign ch3_acc.wdata = dat_i[CH3_W-1:0];
    assign ch6_acc.wdata = dat_i[CYC_W-1:0];
    assign ch7_acc.wdata = dat_i[CYC_W-1:0];
    assign ch8_acc.wdata = dat_i[OS_W-1:0];

    always_comb begin
        // direction bits are plain status, not writable
        dir_d = ch6_down_count_i;
        ack_d = req;
        dat_d = 32'h0000_0000;
        if (req && !we_i) begin
            unique case (adr_i)
                CH3_STATUS_OFS: dat_d = {29'h0, ch3_acc.flags};
                CH6_STATUS_OFS: dat_d = {24'h0, dir_q, ch6_acc.flags};
                CH7_STATUS_OFS: dat_d = {24'h0, 4'h0, ch7_acc.flags};
                CH8_STATUS_OFS: dat_d = {16'h0, ch8_acc.flags};
                default: dat_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
            dir_q <= 4'h0;
        end else begin
            ack_q <= ack_d;
            dat_q <= dat_d;
            dir_q <= dir_d;
        end
    end

    assign ack_o = ack_q;
    assign dat_o = dat_q;
endmodule : timer_status_flag_bank
`default_nettype wire

// file: pkg/flag_bank_pkg.sv
// constants and types for the timer status flag bank
// Functional notes
// - ch3 flags A-C clear only by 0-write after being read as 1.
// - capture into ch3 register A-C sets its flag in capture mode.
// - captures triggered by channel 9 compare match do not set ch3 flags.
// - ch3 counter equal to register A-C sets flag in compare mode.
// - in ch3 PWM mode flags A and B are never set.
// - bits 15..8 of ch6 and ch7 status read 0; software writes 0.
// - ch6 bits 7..4 are read-only directions D..A, 1 means down.
// - ch7 direction bit positions always read 0.
// - cycle flags bits 3..0 clear by 0-write after read as 1.
// - outside complementary PWM, counter equal cycle register sets cycle flag.
// - complementary PWM: ch6 counter A-C at zero counting down sets flag.
// - only a 0-write affects a clearable flag; otherwise read-only.
// - ch8 status holds sixteen one-shot flags, bit n for counter n, reset 0.
// - one-shot counter underflow sets its ch8 flag.
// - ch8 flags clear by 0-write after read while 1.
// - ch6 bits 7..4 give direction, ch6/7 bits 3..0 cycle compare status.
package flag_bank_pkg;
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] CH3_STATUS_OFS = 4'h0;
    localparam logic [ADDR_W-1:0] CH6_STATUS_OFS = 4'h4;
    localparam logic [ADDR_W-1:0] CH7_STATUS_OFS = 4'h8;
    localparam logic [ADDR_W-1:0] CH8_STATUS_OFS = 4'hc;
    localparam int DIR_LSB = 4;
    localparam int CYC_W = 4;
    localparam int CH3_W = 3;
    localparam int OS_W = 16;
    localparam logic [15:0] FLAG_RESET = 16'h0000;
    typedef enum logic [1:0] {
        BANK_CH3,
        BANK_CH6,
        BANK_CH7,
        BANK_CH8
    } bank_sel_t;
endpackage : flag_bank_pkg

// file: pkg/flag_access_if.sv
// per-bank read and write-zero strobes
`timescale 1ns/1ps
`default_nettype none
interface flag_access_if #(parameter int W = 16);
    logic rd;
    logic wr;
    logic [W-1:0] wdata;
    logic [W-1:0] flags;
    modport ctrl (output rd, output wr, output wdata, input flags);
    modport bank (input rd, input wr, input wdata, output flags);
endinterface : flag_access_if
`default_nettype wire

// file: core/clear_flag_bank.sv
// bank of read-then-write-zero sticky flags
`timescale 1ns/1ps
`default_nettype none
module clear_flag_bank #(
    parameter int W = 16
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // hardware set events
    input wire logic [W-1:0] set_i,
    // software access
    flag_access_if.bank acc
);
    import flag_bank_pkg::*;
    logic [W-1:0] flag_q, flag_d;
    logic [W-1:0] armed_q, armed_d;
    logic [W-1:0] clr;

    always_comb begin
        // a bit is armed only after a read that returned 1
        clr = acc.wr ? (armed_q & ~acc.wdata) : '0;
        armed_d = armed_q;
        if (acc.rd) begin
            armed_d = flag_q;
        end else if (acc.wr) begin
            armed_d = '0;
        end
        // set beats clear so no event is dropped
        flag_d = (flag_q & ~clr) | set_i;
        armed_d = armed_d & flag_d;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_q <= FLAG_RESET[W-1:0];
            armed_q <= '0;
        end else begin
            flag_q <= flag_d;
            armed_q <= armed_d;
        end
    end

    assign acc.flags = flag_q;
endmodule : clear_flag_bank
`default_nettype wire

// file: core/event_decode.sv
// turns counter events into per-flag set pulses
`timescale 1ns/1ps
`default_nettype none
module event_decode (
    // channel 3
    input wire logic [2:0] ch3_capture_i,
    input wire logic [2:0] ch3_capture_by_ch9_i,
    input wire logic [2:0] ch3_compare_match_i,
    input wire logic [2:0] ch3_is_capture_i,
    input wire logic ch3_pwm_mode_i,
    // channels 6 and 7
    input wire logic [3:0] ch6_period_match_i,
    input wire logic [3:0] ch7_period_match_i,
    input wire logic [2:0] ch6_zero_down_i,
    input wire logic ch6_comp_pwm_i,
    // set outputs
    output logic [2:0] ch3_set_o,
    output logic [3:0] ch6_set_o,
    output logic [3:0] ch7_set_o
);
    import flag_bank_pkg::*;
    logic [2:0] cap;
    logic [2:0] cmp;
    always_comb begin
        cap = ch3_capture_i & ~ch3_capture_by_ch9_i & ch3_is_capture_i;
        cmp = ch3_compare_match_i & ~ch3_is_capture_i;
        ch3_set_o = cap | cmp;
        if (ch3_pwm_mode_i) begin
            ch3_set_o[1:0] = 2'h0;
        end
        if (ch6_comp_pwm_i) begin
            // counter d has no zero event, so it stays quiet here
            ch6_set_o = {1'b0, ch6_zero_down_i};
        end else begin
            ch6_set_o = ch6_period_match_i;
        end
        ch7_set_o = ch7_period_match_i;
    end
endmodule : event_decode
`default_nettype wire

// file: verif/flag_bank_props.sv
// concurrent checks on the status flag bank ports
`timescale 1ns/1ps
`default_nettype none
module flag_bank_props (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus
    input wire logic we_i,
    input wire logic [flag_bank_pkg::ADDR_W-1:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // events
    input wire logic [2:0] ch3_compare_match_i,
    input wire logic [2:0] ch3_is_capture_i,
    input wire logic ch3_pwm_mode_i,
    input wire logic [3:0] ch6_down_count_i,
    input wire logic [3:0] ch6_period_match_i,
    input wire logic [3:0] ch7_period_match_i,
    input wire logic [2:0] ch6_zero_down_i,
    input wire logic ch6_comp_pwm_i,
    input wire logic [15:0] oneshot_underflow_i
);
    import flag_bank_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // read answers; events two edges back landed before the take
    wire rd = ack_o && !we_i;
    wire rd3 = rd && adr_i == CH3_STATUS_OFS;
    wire rd6 = rd && adr_i == CH6_STATUS_OFS;
    wire rd7 = rd && adr_i == CH7_STATUS_OFS;
    wire rd8 = rd && adr_i == CH8_STATUS_OFS;
    wire [2:0] cm3 = ch3_compare_match_i & ~ch3_is_capture_i & {1'b1, {2{!ch3_pwm_mode_i}}};
    rsv_zero_a: assert property ((rd6 || rd7) |-> dat_o[31:8] == 24'h0)
        else $error("reserved bits set");
    ch7_dir_a: assert property (rd7 |-> dat_o[7:4] == 4'h0)
        else $error("ch7 direction set");
    dir_read_a: assert property (rd6 && $past(ch6_down_count_i) ==
        $past(ch6_down_count_i, 2) |-> dat_o[7:4] == $past(ch6_down_count_i, 2))
        else $error("direction wrong");
    os_set_a: assert property (rd8 |->
        (dat_o[15:0] & $past(oneshot_underflow_i, 2)) == $past(oneshot_underflow_i, 2))
        else $error("oneshot flag lost");
    c7_set_a: assert property (rd7 |->
        (dat_o[3:0] & $past(ch7_period_match_i, 2)) == $past(ch7_period_match_i, 2))
        else $error("ch7 cycle flag lost");
    c6_set_a: assert property (rd6 && !$past(ch6_comp_pwm_i, 2) |->
        (dat_o[3:0] & $past(ch6_period_match_i, 2)) == $past(ch6_period_match_i, 2))
        else $error("ch6 cycle flag lost");
    zero_set_a: assert property (rd6 && $past(ch6_comp_pwm_i, 2) |->
        (dat_o[2:0] & $past(ch6_zero_down_i, 2)) == $past(ch6_zero_down_i, 2))
        else $error("ch6 zero flag lost");
    cmp_set_a: assert property (rd3 |->
        (dat_o[2:0] & $past(cm3, 2)) == $past(cm3, 2))
        else $error("ch3 compare flag lost");
endmodule : flag_bank_props
bind timer_status_flag_bank flag_bank_props u_flag_bank_props (.*);
`default_nettype wire

// file: verif/timer_status_flag_bank_tb.sv
// random bench with a flag model for the status flag bank
`timescale 1ns/1ps
`default_nettype none
module timer_status_flag_bank_tb;
    import flag_bank_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o;
    logic [ADDR_W-1:0] adr_i = 0;
    logic [3:0] sel_i = 0, ch6_down_count_i = 0, ch6_period_match_i = 0, ch7_period_match_i = 0;
    logic [31:0] dat_i = 0, dat_o, rd;
    logic [2:0] ch3_capture_i = 0, ch3_capture_by_ch9_i = 0, ch3_compare_match_i = 0;
    logic [2:0] ch3_is_capture_i = 0, ch6_zero_down_i = 0;
    logic ch3_pwm_mode_i = 0, ch6_comp_pwm_i = 0;
    logic [15:0] oneshot_underflow_i = 0;
    int n_mismatch = 0, num_checks = 0, ticks = 0;
    int flg[4], arm[4];
    timer_status_flag_bank u_timer_status_flag_bank (.*);
    initial forever #25 clk_i = ~clk_i;
    // about 2200 cycles expected
    always @(posedge clk_i) begin
        ticks++;
        if (ticks == 10000) begin
            n_mismatch++;
            results();
        end
    end
    task automatic results();
        if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t read %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // waits for ack without a limit of its own; the cycle ceiling ends a hang
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
        input logic [3:0] s);
        {cyc_i, stb_i, we_i, sel_i} <= {2'b11, w, s};
        adr_i <= a;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o;
        {cyc_i, stb_i} <= 2'b00;
        @(posedge clk_i);
    endtask : wb
    // pulses live one cycle; only the write scenario lets one meet a bus take
    task automatic ev();
        logic [2:0] s3;
        ch3_capture_i <= 3'($urandom & $urandom);
        ch3_compare_match_i <= 3'($urandom & $urandom);
        ch6_period_match_i <= 4'($urandom & $urandom);
        ch7_period_match_i <= 4'($urandom & $urandom);
        ch6_zero_down_i <= 3'($urandom & $urandom);
        oneshot_underflow_i <= 16'($urandom & $urandom);
        {ch3_capture_by_ch9_i, ch3_is_capture_i, ch3_pwm_mode_i} <= 7'($urandom);
        {ch6_down_count_i, ch6_comp_pwm_i} <= 5'($urandom);
        @(posedge clk_i);
        s3 = ch3_capture_i & ~ch3_capture_by_ch9_i & ch3_is_capture_i;
        s3 |= ch3_compare_match_i & ~ch3_is_capture_i;
        if (ch3_pwm_mode_i) s3[1:0] = 2'b00;
        flg[0] |= s3;
        flg[1] |= ch6_comp_pwm_i ? ch6_zero_down_i : ch6_period_match_i;
        flg[2] |= ch7_period_match_i;
        flg[3] |= oneshot_underflow_i;
        {ch3_capture_i, ch3_compare_match_i, ch6_period_match_i} <= '0;
        {ch7_period_match_i, ch6_zero_down_i, oneshot_underflow_i} <= '0;
    endtask : ev
    initial begin
        logic [3:0] a;
        logic [31:0] d, e;
        int i;
        logic [15:0] u;
        logic [3:0] s;
        void'($urandom(32'hd809));
        repeat (6) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        for (int j = 0; j < 4; j++) begin
            wb(0, 4'(4 * j), 0, 4'hf);
            chk(rd, 0);
        end
        for (int k = 0; k < 400; k++) begin
            ev();
            a = 4'(($urandom % 4) * 4 + (k % 9 == 4));
            i = a[3:2];
            e = 0;
            if (a[1:0] == 0) begin
                e = flg[i] | (i == 1 ? 32'(ch6_down_count_i) << 4 : 0);
                arm[i] = flg[i];
            end
            wb(0, a, 0, 4'hf);
            chk(rd, e);
            if ($urandom % 2) begin
                d = $urandom & 32'hffff;
                if (i < 3) d[15:8] = 0;
                s = 4'($urandom);
                u = 16'($urandom & $urandom);
                // one-shot pulse held for the write's take edge only
                fork
                    wb(1, a, d, s);
                    begin
                        oneshot_underflow_i <= u;
                        @(posedge clk_i);
                        oneshot_underflow_i <= '0;
                    end
                join
                // writes without the needed byte lanes leave flags and arming alone
                if (a[1:0] == 0 && (i < 3 ? s[0] : s[1:0] == 2'b11)) begin
                    flg[i] &= ~(arm[i] & ~d);
                    arm[i] = 0;
                end
                flg[3] |= u;
            end
        end
        results();
    end
endmodule : timer_status_flag_bank_tb
`default_nettype wire
